// ---- include/frtic_pkg.sv ----
`default_nettype none
package frtic_pkg;
	// =====================================================
	// Register offsets (byte addresses, one word each).
	localparam logic [7:0] OFF_CTRL_ONE  = 8'h00;
	localparam logic [7:0] OFF_CTRL_TWO  = 8'h04;
	localparam logic [7:0] OFF_STATUS    = 8'h08;
	localparam logic [7:0] OFF_CNT_HI    = 8'h0C;
	localparam logic [7:0] OFF_CNT_LO    = 8'h10;
	localparam logic [7:0] OFF_ALT_HI    = 8'h14;
	localparam logic [7:0] OFF_ALT_LO    = 8'h18;
	localparam logic [7:0] OFF_CAP1_HI   = 8'h1C;
	localparam logic [7:0] OFF_CAP1_LO   = 8'h20;
	localparam logic [7:0] OFF_CAP2_HI   = 8'h24;
	localparam logic [7:0] OFF_CAP2_LO   = 8'h28;
	// =====================================================
	// Field positions.
	localparam int CR1_CAP_IE   = 7;
	localparam int CR1_OVF_IE   = 5;
	localparam int CR1_EDGE1    = 1;
	localparam int CR2_PWM      = 7;
	localparam int CR2_OPM      = 4;
	localparam int CR2_CS_LSB   = 2;
	localparam int CR2_EDGE2    = 1;
	localparam int CR2_EXT_EDGE = 0;
	localparam int SR_CAP1      = 7;
	localparam int SR_CAP2      = 6;
	localparam int SR_OVF       = 5;
	// =====================================================
	// Reset values and counter constants.
	localparam logic [7:0]  CR1_RESET   = 8'h00;
	localparam logic [7:0]  CR2_RESET   = 8'h00;
	localparam logic [15:0] CNT_RELOAD  = 16'hFFFC;
	localparam logic [15:0] CNT_TOP     = 16'hFFFF;
	// =====================================================
	// Clock select codes and prescaler masks.
	localparam logic [1:0] CS_DIV4 = 2'b00;
	localparam logic [1:0] CS_DIV2 = 2'b01;
	localparam logic [1:0] CS_DIV8 = 2'b10;
	localparam logic [1:0] CS_EXT  = 2'b11;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;
endpackage
`default_nettype wire

// ---- include/frtic_cap_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface frtic_cap_if;
	logic [15:0] count;
	logic        edge_sel;
	logic        enable;
	logic        rd_hi;
	logic        rd_lo;
	logic        acc_lo;
	logic        arm;
	logic [15:0] value;
	logic        flag;
	modport timer (output count, edge_sel, enable, rd_hi, rd_lo,
		acc_lo, arm, input value, flag);
	modport chan (input count, edge_sel, enable, rd_hi, rd_lo,
		acc_lo, arm, output value, flag);
endinterface
`default_nettype wire

// ---- hw/frtic_capture_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module frtic_capture_chan (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   pin,
	frtic_cap_if.chan   bus
);
	logic        s1_reg;
	logic        s2_reg;
	logic        s3_reg;
	logic        inhib_reg;
	logic        arm_reg;
	logic        flag_reg;
	logic [15:0] value_reg;
	logic        edge_hit;
	logic        cap_set;

	// =====================================================
	// Pin synchroniser and edge detection.
	// pin always watched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign edge_hit = bus.edge_sel ? (s2_reg & ~s3_reg)
		: (~s2_reg & s3_reg);
	assign cap_set = edge_hit & bus.enable & ~inhib_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inhib_reg <= 1'b0;
		end else if (bus.rd_hi) begin
			inhib_reg <= 1'b1;
		end else if (bus.rd_lo) begin
			inhib_reg <= 1'b0;
		end
	end

	// =====================================================
	// Capture register and flag.
	// latch count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= 16'h0000;
		end else if (cap_set) begin
			value_reg <= bus.count;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_reg  <= 1'b0;
			flag_reg <= 1'b0;
		end else begin
			if (bus.arm && flag_reg) begin
				arm_reg <= 1'b1;
			end else if (bus.acc_lo) begin
				arm_reg <= 1'b0;
			end
			if (cap_set) begin
				flag_reg <= 1'b1;
			end else if (bus.acc_lo && arm_reg) begin
				flag_reg <= 1'b0;
			end
		end
	end

	assign bus.value = value_reg;
	assign bus.flag  = flag_reg;

	AST_CAP_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		cap_set |=> (value_reg == $past(bus.count)) && flag_reg)
		else $error("capture did not load count and flag");
	AST_CAP_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
		inhib_reg && !bus.rd_lo |=> $stable(value_reg))
		else $error("capture changed while inhibited");
	AST_CAP_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		arm_reg && bus.acc_lo && !cap_set |=> !flag_reg)
		else $error("capture flag not cleared by sequence");
endmodule // frtic_capture_chan
`default_nettype wire

// ---- hw/frtic_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module frtic_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_input_1,
	input  wire logic        capture_input_2,
	input  wire logic        ext_count_clock_pin,
	input  wire logic        irq_mask,
	input  wire logic        halt_mode,
	output logic             timer_irq
);
	logic [7:0]  cr1_reg;
	logic [7:0]  cr2_reg;
	logic [15:0] cnt_reg;
	logic [2:0]  presc_reg;
	logic        ovf_flag_reg;
	logic        ovf_arm_reg;
	logic [7:0]  lo_buf_main_reg;
	logic [7:0]  lo_buf_alt_reg;
	logic        pend_main_reg;
	logic        pend_alt_reg;
	logic        ext1_reg;
	logic        ext2_reg;
	logic        ext3_reg;
	logic [31:0] prdata_reg;
	logic        err_reg;
	logic        setup;
	logic        rd_set;
	logic        wr_acc;
	logic        acc_cl;
	logic        acc_acl;
	logic        reload;
	logic        tick;
	logic        int_tick;
	logic        ext_edge;
	logic        ovf_set;
	logic        mapped;
	logic [2:0]  mask;
	logic [1:0]  clock_select_field;
	logic        overflow_irq_enable;
	logic        capture_irq_enable;
	logic        pwm_operation;
	logic        one_pulse_operation;
	logic        ext_clock_edge_select;
	logic [7:0]  status;
	logic [7:0]  rd_mux;

	frtic_cap_if cap1_if ();
	frtic_cap_if cap2_if ();

	// =====================================================
	// Control fields.
	assign capture_irq_enable = cr1_reg[frtic_pkg::CR1_CAP_IE];
	assign overflow_irq_enable = cr1_reg[frtic_pkg::CR1_OVF_IE];
	assign pwm_operation = cr2_reg[frtic_pkg::CR2_PWM];
	assign one_pulse_operation = cr2_reg[frtic_pkg::CR2_OPM];
	assign clock_select_field =
		cr2_reg[frtic_pkg::CR2_CS_LSB+1:frtic_pkg::CR2_CS_LSB];
	assign ext_clock_edge_select = cr2_reg[frtic_pkg::CR2_EXT_EDGE];

	// =====================================================
	// APB decode.
	assign setup  = psel & ~penable;
	assign rd_set = setup & ~pwrite;
	assign wr_acc = psel & penable & pwrite & pstrb[0];
	assign acc_cl = (rd_set | wr_acc) & (paddr == frtic_pkg::OFF_CNT_LO);
	assign acc_acl = (rd_set | wr_acc) & (paddr == frtic_pkg::OFF_ALT_LO);
	assign reload = wr_acc & ((paddr == frtic_pkg::OFF_CNT_LO)
		| (paddr == frtic_pkg::OFF_ALT_LO));

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			frtic_pkg::OFF_CTRL_ONE, frtic_pkg::OFF_CTRL_TWO,
			frtic_pkg::OFF_STATUS, frtic_pkg::OFF_CNT_HI,
			frtic_pkg::OFF_CNT_LO, frtic_pkg::OFF_ALT_HI,
			frtic_pkg::OFF_ALT_LO, frtic_pkg::OFF_CAP1_HI,
			frtic_pkg::OFF_CAP1_LO, frtic_pkg::OFF_CAP2_HI,
			frtic_pkg::OFF_CAP2_LO: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cr1_reg <= frtic_pkg::CR1_RESET;
			cr2_reg <= frtic_pkg::CR2_RESET;
		end else if (wr_acc && paddr == frtic_pkg::OFF_CTRL_ONE) begin
			cr1_reg <= pwdata[7:0] & 8'hA2;
		end else if (wr_acc && paddr == frtic_pkg::OFF_CTRL_TWO) begin
			cr2_reg <= pwdata[7:0] & 8'h9F;
		end
	end

	// =====================================================
	// Read data path.
	always_comb begin
		status = 8'h00;
		status[frtic_pkg::SR_CAP1] = cap1_if.flag;
		status[frtic_pkg::SR_CAP2] = cap2_if.flag;
		status[frtic_pkg::SR_OVF]  = ovf_flag_reg;
		case (paddr)
			frtic_pkg::OFF_CTRL_ONE: rd_mux = cr1_reg;
			frtic_pkg::OFF_CTRL_TWO: rd_mux = cr2_reg;
			frtic_pkg::OFF_STATUS:   rd_mux = status;
			frtic_pkg::OFF_CNT_HI:   rd_mux = cnt_reg[15:8];
			frtic_pkg::OFF_ALT_HI:   rd_mux = cnt_reg[15:8];
			frtic_pkg::OFF_CNT_LO:
				rd_mux = pend_main_reg ? lo_buf_main_reg : cnt_reg[7:0];
			frtic_pkg::OFF_ALT_LO:
				rd_mux = pend_alt_reg ? lo_buf_alt_reg : cnt_reg[7:0];
			frtic_pkg::OFF_CAP1_HI:  rd_mux = cap1_if.value[15:8];
			frtic_pkg::OFF_CAP1_LO:  rd_mux = cap1_if.value[7:0];
			frtic_pkg::OFF_CAP2_HI:  rd_mux = cap2_if.value[15:8];
			frtic_pkg::OFF_CAP2_LO:  rd_mux = cap2_if.value[7:0];
			default:                 rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			err_reg    <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
			err_reg    <= ~mapped;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & err_reg;

	// =====================================================
	// Sixteen bit read buffers.
	// buffer low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_buf_main_reg <= 8'h00;
			pend_main_reg   <= 1'b0;
		end else if (rd_set && paddr == frtic_pkg::OFF_CNT_HI) begin
			if (!pend_main_reg) begin
				lo_buf_main_reg <= cnt_reg[7:0];
			end
			pend_main_reg <= 1'b1;
		end else if (rd_set && paddr == frtic_pkg::OFF_CNT_LO) begin
			pend_main_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_buf_alt_reg <= 8'h00;
			pend_alt_reg   <= 1'b0;
		end else if (rd_set && paddr == frtic_pkg::OFF_ALT_HI) begin
			if (!pend_alt_reg) begin
				lo_buf_alt_reg <= cnt_reg[7:0];
			end
			pend_alt_reg <= 1'b1;
		end else if (rd_set && paddr == frtic_pkg::OFF_ALT_LO) begin
			pend_alt_reg <= 1'b0;
		end
	end

	// =====================================================
	// Counter clocking.
	// external clock sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext1_reg <= 1'b0;
			ext2_reg <= 1'b0;
			ext3_reg <= 1'b0;
		end else begin
			ext1_reg <= ext_count_clock_pin;
			ext2_reg <= ext1_reg;
			ext3_reg <= ext2_reg;
		end
	end

	assign ext_edge = ext_clock_edge_select ? (ext2_reg & ~ext3_reg)
		: (~ext2_reg & ext3_reg);

	always_comb begin
		case (clock_select_field)
			frtic_pkg::CS_DIV2: mask = frtic_pkg::MASK_DIV2;
			frtic_pkg::CS_DIV4: mask = frtic_pkg::MASK_DIV4;
			default:            mask = frtic_pkg::MASK_DIV8;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= 3'h0;
		end else if (!halt_mode) begin
			presc_reg <= presc_reg + 3'h1;
		end
	end

	assign int_tick = (presc_reg & mask) == mask;
	assign tick = !halt_mode && ((clock_select_field == frtic_pkg::CS_EXT)
		? ext_edge : int_tick);
	assign ovf_set = tick && !reload && (cnt_reg == frtic_pkg::CNT_TOP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= frtic_pkg::CNT_RELOAD;
		end else if (reload) begin
			cnt_reg <= frtic_pkg::CNT_RELOAD;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// =====================================================
	// Overflow flag and interrupt.
	// two step clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_arm_reg  <= 1'b0;
			ovf_flag_reg <= 1'b0;
		end else begin
			if (rd_set && paddr == frtic_pkg::OFF_STATUS && ovf_flag_reg) begin
				ovf_arm_reg <= 1'b1;
			end else if (acc_cl) begin
				ovf_arm_reg <= 1'b0;
			end
			if (ovf_set) begin
				ovf_flag_reg <= 1'b1;
			end else if (acc_cl && ovf_arm_reg) begin
				ovf_flag_reg <= 1'b0;
			end
		end
	end

	assign timer_irq = !irq_mask && ((ovf_flag_reg && overflow_irq_enable)
		|| ((cap1_if.flag || cap2_if.flag) && capture_irq_enable));

	// =====================================================
	// Capture channels.
	assign cap1_if.count    = cnt_reg;
	assign cap1_if.edge_sel = cr1_reg[frtic_pkg::CR1_EDGE1];
	assign cap1_if.enable   = !(one_pulse_operation || pwm_operation);
	assign cap1_if.rd_hi    = rd_set && paddr == frtic_pkg::OFF_CAP1_HI;
	assign cap1_if.rd_lo    = rd_set && paddr == frtic_pkg::OFF_CAP1_LO;
	assign cap1_if.acc_lo   = (rd_set || wr_acc)
		&& paddr == frtic_pkg::OFF_CAP1_LO;
	assign cap1_if.arm      = rd_set && paddr == frtic_pkg::OFF_STATUS;
	assign cap2_if.count    = cnt_reg;
	assign cap2_if.edge_sel = cr2_reg[frtic_pkg::CR2_EDGE2];
	assign cap2_if.enable   = 1'b1;
	assign cap2_if.rd_hi    = rd_set && paddr == frtic_pkg::OFF_CAP2_HI;
	assign cap2_if.rd_lo    = rd_set && paddr == frtic_pkg::OFF_CAP2_LO;
	assign cap2_if.acc_lo   = (rd_set || wr_acc)
		&& paddr == frtic_pkg::OFF_CAP2_LO;
	assign cap2_if.arm      = rd_set && paddr == frtic_pkg::OFF_STATUS;

	frtic_capture_chan u_cap1 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (capture_input_1),
		.bus     (cap1_if.chan)
	);

	frtic_capture_chan u_cap2 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (capture_input_2),
		.bus     (cap2_if.chan)
	);

	// =====================================================
	// Checks.
	AST_DIV2_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		clock_select_field == frtic_pkg::CS_DIV2 && tick ##1 !halt_mode
		|-> !int_tick ##1 presc_reg[0])
		else $error("divide by two spacing wrong");
	AST_ALT_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		acc_acl && ovf_flag_reg |=> ovf_flag_reg)
		else $error("shadow low access cleared overflow");
	AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
		reload |=> cnt_reg == 16'hFFFC)
		else $error("low write did not reload counter");
	AST_ONLY_STEP: assert property (@(posedge pclk) disable iff (!presetn)
		!$stable(cnt_reg) |-> cnt_reg == 16'hFFFC
		|| cnt_reg == $past(cnt_reg) + 16'h0001)
		else $error("counter moved to an illegal value");
	AST_HOLD_BUF: assert property (@(posedge pclk) disable iff (!presetn)
		pend_main_reg && $past(pend_main_reg) |-> $stable(lo_buf_main_reg))
		else $error("buffered low byte changed");
	AST_LIVE_LO: assert property (@(posedge pclk) disable iff (!presetn)
		rd_set && paddr == frtic_pkg::OFF_CNT_LO && !pend_main_reg
		|=> prdata[7:0] == $past(cnt_reg[7:0]))
		else $error("lone low read not live");
	AST_OVF_SET: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !reload && cnt_reg == 16'hFFFF
		|=> ovf_flag_reg && cnt_reg == 16'h0000)
		else $error("wrap did not set overflow");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		ovf_flag_reg && overflow_irq_enable |-> timer_irq == !irq_mask)
		else $error("overflow interrupt wrong");
	AST_OVF_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		ovf_arm_reg && acc_cl && !ovf_set |=> !ovf_flag_reg)
		else $error("overflow not cleared by sequence");
	AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode && !reload |=> $stable(cnt_reg))
		else $error("counter moved in halt");
	AST_EXT: assert property (@(posedge pclk) disable iff (!presetn)
		clock_select_field == frtic_pkg::CS_EXT && !halt_mode
		|-> tick == ext_edge)
		else $error("external clock not followed");
	AST_CH1_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(one_pulse_operation || pwm_operation) && !cap1_if.flag
		|=> !cap1_if.flag && $stable(cap1_if.value))
		else $error("channel one captured in pulse operation");
endmodule // frtic_timer
`default_nettype wire

// ---- dv/frtic_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Far side pins: two capture sources and an external count clock.
module frtic_pin_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic cap1_lvl,
	input  wire logic cap2_lvl,
	input  wire logic ext_lvl,
	input  wire logic ext_run,
	output logic      capture_input_1,
	output logic      capture_input_2,
	output logic      ext_count_clock_pin
);
	logic [1:0] gap_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_input_1 <= 1'b0;
			capture_input_2 <= 1'b0;
		end else begin
			capture_input_1 <= cap1_lvl;
			capture_input_2 <= cap2_lvl;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg <= 2'h0;
			ext_count_clock_pin <= 1'b0;
		end else if (ext_run) begin
			gap_reg <= gap_reg + 2'h1;
			if (gap_reg == 2'h3) begin
				ext_count_clock_pin <= ~ext_count_clock_pin;
			end
		end else begin
			ext_count_clock_pin <= ext_lvl;
		end
	end
endmodule // frtic_pin_model
`default_nettype wire

// ---- dv/free_running_timer_input_capture_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module free_running_timer_input_capture_tb_top;
	// =====================================================
	// Signals.
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0000_0000;
	logic        irq_mask  = 1'b0;
	logic        halt_mode = 1'b1;
	logic        cap1_lvl  = 1'b0;
	logic        cap2_lvl  = 1'b0;
	logic        ext_lvl   = 1'b0;
	logic        ext_run   = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer_irq;
	logic        cap_1;
	logic        cap_2;
	logic        ext_pin;
	logic [31:0] rd;
	logic        err;
	logic [15:0] v;
	logic [15:0] c;
	logic [15:0] e;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          dv [3] = '{2, 4, 8};
	logic [1:0]  cs [3] = '{frtic_pkg::CS_DIV2, frtic_pkg::CS_DIV4,
		frtic_pkg::CS_DIV8};
	logic [7:0]  md [2] = '{8'h10, 8'h80};

	frtic_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_input_1(cap_1),
		.capture_input_2(cap_2), .ext_count_clock_pin(ext_pin),
		.irq_mask(irq_mask), .halt_mode(halt_mode), .timer_irq(timer_irq));

	frtic_pin_model far (.pclk(pclk), .presetn(presetn),
		.cap1_lvl(cap1_lvl), .cap2_lvl(cap2_lvl), .ext_lvl(ext_lvl),
		.ext_run(ext_run), .capture_input_1(cap_1),
		.capture_input_2(cap_2), .ext_count_clock_pin(ext_pin));

	always #5 pclk = ~pclk;

	// =====================================================
	// Tasks.
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_rng(input logic [15:0] got,
		input logic [15:0] lo, input logic [15:0] hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("BAD t=%0t got %h not in %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic get16(input logic [7:0] a, output logic [15:0] r);
		apb(1'b0, a, 8'h00);
		r[15:8] = rd[7:0];
		apb(1'b0, a + 8'h04, 8'h00);
		r[7:0] = rd[7:0];
	endtask

	task automatic st_bit(input int b, input logic x);
		apb(1'b0, frtic_pkg::OFF_STATUS, 8'h00);
		check({15'h0, rd[b]}, {15'h0, x});
	endtask

	task automatic ext_step(input logic l, input logic [15:0] x);
		ext_lvl <= l;
		cyc(8);
		get16(frtic_pkg::OFF_CNT_HI, v);
		check(v, x);
	endtask

	task automatic cap_step(input logic l1, input logic l2);
		cap1_lvl <= l1;
		cap2_lvl <= l2;
		cyc(8);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// =====================================================
	// Tests.
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, frtic_pkg::OFF_CTRL_TWO, 8'h00);
		check({8'h00, rd[7:0]}, {8'h00, frtic_pkg::CR2_RESET});
		get16(frtic_pkg::OFF_CNT_HI, v);
		check(v, frtic_pkg::CNT_RELOAD);
		get16(frtic_pkg::OFF_ALT_HI, v);
		check(v, frtic_pkg::CNT_RELOAD);
		apb(1'b0, 8'h2C, 8'h00);
		check({15'h0, err}, 16'h0001);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, frtic_pkg::OFF_CTRL_TWO, {4'h0, cs[i], 2'h0});
			apb(1'b1, i[0] ? frtic_pkg::OFF_ALT_LO : frtic_pkg::OFF_CNT_LO,
				8'h00);
			halt_mode <= 1'b0;
			cyc(80);
			halt_mode <= 1'b1;
			get16(frtic_pkg::OFF_CNT_HI, v);
			e = frtic_pkg::CNT_RELOAD + 16'(80 / dv[i]);
			check_rng(v, e - 16'h0001, e + 16'h0001);
			c = v;
			cyc(20);
			get16(frtic_pkg::OFF_CNT_HI, v);
			check(v, c);
		end
		$display("test prescaler done");
		st_bit(frtic_pkg::SR_OVF, 1'b1);
		apb(1'b1, frtic_pkg::OFF_CTRL_ONE, 8'h20);
		cyc(2);
		check({15'h0, timer_irq}, 16'h0001);
		irq_mask <= 1'b1;
		cyc(2);
		check({15'h0, timer_irq}, 16'h0000);
		irq_mask <= 1'b0;
		cyc(2);
		check({15'h0, timer_irq}, 16'h0001);
		apb(1'b0, frtic_pkg::OFF_ALT_LO, 8'h00);
		st_bit(frtic_pkg::SR_OVF, 1'b1);
		apb(1'b0, frtic_pkg::OFF_CNT_LO, 8'h00);
		st_bit(frtic_pkg::SR_OVF, 1'b0);
		check({15'h0, timer_irq}, 16'h0000);
		$display("test overflow done");
		apb(1'b1, frtic_pkg::OFF_CTRL_TWO, {4'h0, frtic_pkg::CS_DIV2, 2'h0});
		apb(1'b1, frtic_pkg::OFF_CNT_LO, 8'h00);
		apb(1'b0, frtic_pkg::OFF_CNT_HI, 8'h00);
		halt_mode <= 1'b0;
		cyc(40);
		halt_mode <= 1'b1;
		apb(1'b0, frtic_pkg::OFF_CNT_HI, 8'h00);
		check({8'h00, rd[7:0]}, 16'h0000);
		apb(1'b0, frtic_pkg::OFF_CNT_LO, 8'h00);
		check({8'h00, rd[7:0]}, 16'h00FC);
		apb(1'b0, frtic_pkg::OFF_CNT_LO, 8'h00);
		check_rng({8'h00, rd[7:0]}, 16'h000F, 16'h0011);
		$display("test read pair done");
		apb(1'b1, frtic_pkg::OFF_CTRL_TWO, 8'h0D);
		halt_mode <= 1'b0;
		apb(1'b1, frtic_pkg::OFF_CNT_LO, 8'h00);
		ext_step(1'b1, 16'hFFFD);
		ext_step(1'b0, 16'hFFFD);
		apb(1'b1, frtic_pkg::OFF_CTRL_TWO, 8'h0C);
		ext_step(1'b1, 16'hFFFD);
		ext_step(1'b0, 16'hFFFE);
		ext_run <= 1'b1;
		cyc(80);
		ext_run <= 1'b0;
		cyc(8);
		get16(frtic_pkg::OFF_CNT_HI, v);
		check_rng(v, 16'h0007, 16'h000A);
		$display("test external clock done");
		c = v;
		apb(1'b1, frtic_pkg::OFF_CTRL_ONE, 8'h82);
		cap_step(1'b1, 1'b1);
		check({15'h0, timer_irq}, 16'h0001);
		st_bit(frtic_pkg::SR_CAP1, 1'b1);
		st_bit(frtic_pkg::SR_CAP2, 1'b0);
		get16(frtic_pkg::OFF_CAP1_HI, v);
		check(v, c);
		st_bit(frtic_pkg::SR_CAP1, 1'b0);
		cap_step(1'b1, 1'b0);
		st_bit(frtic_pkg::SR_CAP2, 1'b1);
		get16(frtic_pkg::OFF_CAP2_HI, v);
		check(v, c);
		apb(1'b0, frtic_pkg::OFF_CAP1_HI, 8'h00);
		ext_step(1'b1, c);
		ext_step(1'b0, c + 16'h0001);
		cap_step(1'b0, 1'b0);
		cap_step(1'b1, 1'b0);
		st_bit(frtic_pkg::SR_CAP1, 1'b0);
		apb(1'b0, frtic_pkg::OFF_CAP1_LO, 8'h00);
		check({8'h00, rd[7:0]}, {8'h00, c[7:0]});
		cap_step(1'b0, 1'b0);
		cap_step(1'b1, 1'b0);
		get16(frtic_pkg::OFF_CAP1_HI, v);
		check(v, c + 16'h0001);
		$display("test capture done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, frtic_pkg::OFF_CTRL_TWO, md[i] | 8'h0C);
			apb(1'b0, frtic_pkg::OFF_STATUS, 8'h00);
			apb(1'b0, frtic_pkg::OFF_CAP1_LO, 8'h00);
			apb(1'b0, frtic_pkg::OFF_CAP2_LO, 8'h00);
			cap_step(1'b0, 1'b1);
			cap_step(1'b1, 1'b0);
			st_bit(frtic_pkg::SR_CAP1, 1'b0);
			st_bit(frtic_pkg::SR_CAP2, 1'b1);
		end
		$display("test pulse modes done");
		test_done;
	end

	// =====================================================
	// Watchdog.
	initial begin
		cyc(20000);
		n_mismatch++;
		$display("BAD t=%0t watchdog expired", $time);
		test_done;
	end
endmodule // free_running_timer_input_capture_tb_top
`default_nettype wire
